/* verilog/ihl_hazard_top.sv */
// Purpose: Fetch-block register hazards, replay ordering, address modes, trap lock
// Assumes: Pipeline inputs are on clk_in; AHB-Lite slave answers with no waits
// Notes:   Status flags are sticky, write one to clear, a new event wins
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ihl_hazard_top
  import ihl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        enq_valid_in,
  input  wire logic [15:0] enq_pc_in,
  input  wire logic [2:0]  enq_kind_in,
  input  wire logic [2:0]  enq_group_in,
  input  wire logic        iss_move_from_in,
  input  wire logic        iss_move_to_in,
  input  wire logic        move_to_retire_in,
  input  wire logic        replay_trap_in,
  input  wire logic [15:0] replay_pc_in,
  input  wire logic        refetch_issue_in,
  input  wire logic        priv_mode_in,
  input  wire logic        priv_jump_in,
  input  wire logic [63:0] fetch_target_in,
  input  wire logic        dvaddr_valid_in,
  input  wire logic [63:0] dvaddr_in,
  input  wire logic        trap_in,
  input  wire logic        retire_in,
  input  wire logic        taken_retire_in,
  input  wire logic        exc_req_in,
  input  wire logic        dfault_in,
  output logic             rmw_hold_out,
  output logic             hold_newer_ldst_out,
  output logic             cancel_dirty_out,
  output logic             ifetch_acv_out,
  output logic             dacv_out,
  output logic             fetch_wide_out,
  output logic             data_wide_out,
  output logic             exc_regs_wen_out,
  output logic             exc_defer_out,
  output logic             dfault_regs_wen_out
);
  // ==========================================================
  // Decoding helpers
  function automatic logic [7:0] grp_hot(input logic [2:0] g);
    grp_hot = 8'h01 << g;
  endfunction

  // Address is legal when all bits above top copy the top bit
  function automatic logic sext_ok(input logic [63:0] a, input logic wide);
    logic [63:0] hi;
    hi = wide ? (a >> IHL_WIDE_TOP) : (a >> IHL_NARROW_TOP);
    if (wide) begin
      sext_ok = (hi[16:0] == 17'h00000) || (hi[16:0] == 17'h1FFFF);
    end else begin
      sext_ok = (hi[21:0] == 22'h000000) || (hi[21:0] == 22'h3FFFFF);
    end
  endfunction

  ihl_lock_if lk ();

  ihl_trap_lock u_lock (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .lk        (lk)
  );

  // ==========================================================
  // AHB-Lite slave
  logic        ap_wr_q;
  logic [7:0]  ap_addr_q;
  logic        ap_go;
  logic [1:0]  if_pend_q;
  logic [1:0]  va_pend_q;
  logic [1:0]  if_cur_q;
  logic [1:0]  va_cur_q;
  logic        if_dirty_q;
  logic        va_dirty_q;
  logic [IHL_NFLAGS-1:0] flags_q;
  logic [IHL_NFLAGS-1:0] flag_set;
  logic [IHL_NFLAGS-1:0] flag_clr;
  logic [3:0]  gap_q;
  logic        armed_q;
  logic [31:0] rd_mux;

  assign ap_go = hsel_in && htrans_in[1] && hready_in;

  // Capture address phase
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready_in) begin
      ap_wr_q   <= ap_go && hwrite_in;
      ap_addr_q <= haddr_in[7:0];
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr_in[7:0])
      IHL_IFETCH_CTRL_OFF: begin
        rd_mux[1:0] = if_pend_q;
        rd_mux[IHL_COMMITTED_POS +: 2] = if_cur_q;
      end
      IHL_VADDR_CTRL_OFF: begin
        rd_mux[1:0] = va_pend_q;
        rd_mux[IHL_COMMITTED_POS +: 2] = va_cur_q;
      end
      IHL_STATUS_OFF: begin
        rd_mux[IHL_NFLAGS-1:0] = flags_q;
        rd_mux[IHL_LOCKED_POS] = lk.locked;
        rd_mux[IHL_ARMED_POS] = armed_q;
        rd_mux[IHL_CNT_POS +: 3] = lk.count;
      end
      IHL_GAP_OFF: rd_mux[3:0] = gap_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Registered read data, always ready and OKAY
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      if (ap_go && !hwrite_in) begin
        hrdata_out <= rd_mux;
      end
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  // ==========================================================
  // Mode bits: staged by software, live once the move-to retires
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      if_pend_q  <= IHL_CTRL_RESET;
      va_pend_q  <= IHL_CTRL_RESET;
      if_cur_q   <= IHL_CTRL_RESET;
      va_cur_q   <= IHL_CTRL_RESET;
      if_dirty_q <= 1'b0;
      va_dirty_q <= 1'b0;
    end else begin
      if (ap_wr_q && ap_addr_q == IHL_IFETCH_CTRL_OFF) begin
        if_pend_q  <= hwdata_in[1:0];
        if_dirty_q <= 1'b1;
      end else if (move_to_retire_in && if_dirty_q) begin
        if_cur_q   <= if_pend_q;
        if_dirty_q <= 1'b0;
      end
      if (ap_wr_q && ap_addr_q == IHL_VADDR_CTRL_OFF) begin
        va_pend_q  <= hwdata_in[1:0];
        va_dirty_q <= 1'b1;
      end else if (move_to_retire_in && va_dirty_q) begin
        va_cur_q   <= va_pend_q;
        va_dirty_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Fetch block hazard tracking
  logic [11:0] blk_q;
  logic [7:0]  wr_grp_q;
  logic        same_blk;
  logic [7:0]  seen;
  logic [7:0]  ghot;

  assign same_blk = (enq_pc_in[15:IHL_BLOCK_LO] == blk_q);
  assign seen     = same_blk ? wr_grp_q : 8'h00;
  assign ghot     = grp_hot(enq_group_in);

  // Groups explicitly written so far in the current block
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      blk_q    <= 12'h000;
      wr_grp_q <= 8'h00;
    end else if (enq_valid_in) begin
      blk_q <= enq_pc_in[15:IHL_BLOCK_LO];
      if (enq_kind_in == K_MOVE_TO) begin
        wr_grp_q <= seen | ghot;
      end else begin
        wr_grp_q <= seen;
      end
    end
  end

  // Violations of the placement discipline, plus mode, gap and fetch address events
  logic gap_bad;
  logic ifetch_bad;
  always_comb begin
    flag_set    = '0;
    flag_set[0] = enq_valid_in && enq_kind_in == K_MOVE_TO && |(seen & ghot);
    flag_set[1] = enq_valid_in && enq_kind_in == K_MOVE_FROM && |(seen & ghot);
    flag_set[2] = enq_valid_in && enq_kind_in == K_IMPL_READ && |(seen & ghot);
    flag_set[3] = gap_bad;
    flag_set[4] = !priv_mode_in && (if_cur_q != va_cur_q);
    flag_set[5] = ifetch_bad;
  end

  always_comb begin
    flag_clr = '0;
    if (ap_wr_q && ap_addr_q == IHL_STATUS_OFF) begin
      flag_clr = hwdata_in[IHL_NFLAGS-1:0];
    end
  end

  // Sticky flags, a new event beats the clear
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // ==========================================================
  // Read-modify-write spacing
  logic       rmw_act_q;
  logic [3:0] rmw_cnt_q;

  assign gap_bad = iss_move_to_in && rmw_act_q &&
                   (rmw_cnt_q < IHL_RMW_MIN_GAP || rmw_cnt_q > IHL_RMW_MAX_GAP);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rmw_act_q    <= 1'b0;
      rmw_cnt_q    <= 4'h0;
      rmw_hold_out <= 1'b0;
      gap_q        <= 4'h0;
    end else if (iss_move_from_in) begin
      rmw_act_q    <= 1'b1;
      rmw_cnt_q    <= 4'h1;
      rmw_hold_out <= 1'b1;
    end else begin
      if ((rmw_act_q || rmw_hold_out) && rmw_cnt_q != 4'hF) begin
        rmw_cnt_q <= rmw_cnt_q + 4'h1; // Keeps counting while hold runs out
      end
      rmw_hold_out <= rmw_hold_out && (rmw_cnt_q + 4'h1 < IHL_RMW_MIN_GAP);
      if (iss_move_to_in && rmw_act_q) begin
        gap_q     <= rmw_cnt_q;
        rmw_act_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Replay trap ordering and dirty check cancel
  logic [1:0] rslot_q;
  logic       intq_kind;

  assign intq_kind = enq_kind_in == K_INT_OP || enq_kind_in == K_FP_STORE ||
                     enq_kind_in == K_INT_TO_FP_MOVE || enq_kind_in == K_LOAD;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_newer_ldst_out <= 1'b0;
    end else if (replay_trap_in) begin
      hold_newer_ldst_out <= 1'b1;
    end else if (refetch_issue_in) begin
      hold_newer_ldst_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rslot_q          <= 2'h0;
      armed_q          <= 1'b0;
      cancel_dirty_out <= 1'b0;
    end else begin
      cancel_dirty_out <= 1'b0;
      if (replay_trap_in) begin
        rslot_q <= replay_pc_in[IHL_SLOT_LO +: 2];
        armed_q <= 1'b1;
      end else if (armed_q && enq_valid_in && intq_kind &&
                   enq_pc_in[IHL_SLOT_LO +: 2] == rslot_q) begin
        cancel_dirty_out <= 1'b1;
        armed_q          <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Address width selection and access limits
  assign ifetch_bad = priv_jump_in && !sext_ok(fetch_target_in, if_cur_q[IHL_WIDE_BIT]);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ifetch_acv_out <= 1'b0;
      dacv_out       <= 1'b0;
      fetch_wide_out <= 1'b0;
      data_wide_out  <= 1'b0;
    end else begin
      ifetch_acv_out <= ifetch_bad;
      dacv_out       <= dvaddr_valid_in && !sext_ok(dvaddr_in, va_cur_q[IHL_WIDE_BIT]);
      fetch_wide_out <= if_cur_q[IHL_WIDE_BIT];
      data_wide_out  <= va_cur_q[IHL_WIDE_BIT];
    end
  end

  // ==========================================================
  // Trap lock hookup; data fault registers bypass the lock
  assign lk.trap    = trap_in;
  assign lk.retire  = retire_in;
  assign lk.taken   = taken_retire_in;
  assign lk.exc_req = exc_req_in;
  assign exc_regs_wen_out = lk.take;
  assign exc_defer_out    = lk.defer;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dfault_regs_wen_out <= 1'b0;
    end else begin
      dfault_regs_wen_out <= dfault_in;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  rmw_min_hold_a: assert property (iss_move_from_in |=> rmw_hold_out [*3] ##1 !rmw_hold_out)
    else $error("read-modify-write hold not three cycles");
  dup_group_a: assert property (enq_valid_in && enq_kind_in == K_MOVE_TO && same_blk &&
    |(wr_grp_q & ghot) |=> flags_q[0])
    else $error("duplicate group write not flagged");
  diff_group_a: assert property (enq_valid_in && enq_kind_in == K_MOVE_TO &&
    !(|(seen & ghot)) && !flags_q[0] && !flag_clr[0] |=> !flags_q[0])
    else $error("distinct group writes flagged");
  replay_order_a: assert property (replay_trap_in |=> hold_newer_ldst_out)
    else $error("newer memory ops not held after replay");
  cancel_slot_a: assert property (cancel_dirty_out |-> $past(armed_q) &&
    $past(enq_pc_in[3:2]) == $past(rslot_q))
    else $error("dirty check cancelled in wrong slot");
  cancel_once_a: assert property (cancel_dirty_out |-> !armed_q)
    else $error("cancel left armed");
  commit_retire_a: assert property (if_cur_q != $past(if_cur_q) |-> $past(move_to_retire_in))
    else $error("mode changed without retire");
  dacv_width_a: assert property (dvaddr_valid_in && !va_cur_q[0] && dvaddr_in[43] != dvaddr_in[42]
    |=> dacv_out)
    else $error("narrow data address not caught");
  dfault_free_a: assert property (dfault_in && lk.locked |=> dfault_regs_wen_out)
    else $error("data fault write blocked by lock");
  cov_replay_c: cover property (replay_trap_in ##[1:20] cancel_dirty_out);
  cov_rmw_c: cover property (iss_move_from_in ##[4:9] iss_move_to_in);
  cov_dup_c: cover property (flag_set[0]);
endmodule

/* verilog/ihl_pkg.sv */
// Purpose: Shared constants and types for the firmware hazard and trap lock block
// Assumes: One core clock; pipeline events arrive on that clock
// Notes:   Register offsets are byte addresses on the AHB-Lite slave
package ihl_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] IHL_IFETCH_CTRL_OFF = 8'h00;
  localparam logic [7:0] IHL_VADDR_CTRL_OFF  = 8'h04;
  localparam logic [7:0] IHL_STATUS_OFF      = 8'h08;
  localparam logic [7:0] IHL_GAP_OFF         = 8'h0C;
  localparam logic [1:0] IHL_CTRL_RESET      = 2'h0;
  localparam int         IHL_WIDE_BIT        = 0;
  localparam int         IHL_COMPACT_BIT     = 1;
  localparam int         IHL_COMMITTED_POS   = 16;
  localparam int         IHL_LOCKED_POS      = 8;
  localparam int         IHL_ARMED_POS       = 9;
  localparam int         IHL_CNT_POS         = 12;
  localparam int         IHL_NFLAGS          = 6;
  // ==========================================================
  // Fetch block, address widths and timing
  localparam int         IHL_SLOT_LO     = 2;
  localparam int         IHL_BLOCK_LO    = 4;
  localparam int         IHL_NARROW_TOP  = 42;
  localparam int         IHL_WIDE_TOP    = 47;
  localparam int         IHL_LOCK_INSNS  = 4;
  localparam logic [3:0] IHL_RMW_MIN_GAP = 4'h4;
  localparam logic [3:0] IHL_RMW_MAX_GAP = 4'h9;
  // ==========================================================
  // Instruction kinds seen at enqueue
  typedef enum logic [2:0] {
    K_OTHER     = 3'h0,
    K_MOVE_TO   = 3'h1,
    K_MOVE_FROM = 3'h2,
    K_IMPL_READ = 3'h3,
    K_INT_OP    = 3'h4,
    K_FP_STORE  = 3'h5,
    K_INT_TO_FP_MOVE      = 3'h6,
    K_LOAD      = 3'h7
  } ihl_kind_e;
  // Lock states, Gray along open-held-open
  typedef enum logic [1:0] {
    LK_OPEN = 2'b00,
    LK_HELD = 2'b01
  } ihl_lock_e;
endpackage

/* verilog/ihl_lock_if.sv */
// Purpose: Carries trap lock events and answers between the top and the lock unit
// Assumes: All signals on the core clock
// Notes:   Top drives events, lock unit drives answers from flops
`timescale 1ns/1ps
interface ihl_lock_if;
  logic       trap;
  logic       retire;
  logic       taken;
  logic       exc_req;
  logic       locked;
  logic       take;
  logic       defer;
  logic [2:0] count;
  modport top  (output trap, retire, taken, exc_req, input locked, take, defer, count);
  modport lock (input trap, retire, taken, exc_req, output locked, take, defer, count);
endinterface

/* verilog/ihl_trap_lock.sv */
// Purpose: Locks exception registers after a firmware trap
// Assumes: One retire pulse per retired firmware instruction
// Notes:   Answers are registered one cycle after the request
`timescale 1ns/1ps
module ihl_trap_lock
  import ihl_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  ihl_lock_if.lock  lk
);
  ihl_lock_e  st_q;
  logic [2:0] cnt_q;
  logic       open_w;
  logic       last_w;

  // Delimiter: fourth retire or a taken branch retiring
  assign open_w = (st_q == LK_OPEN);
  assign last_w = lk.retire && (lk.taken || (32'(cnt_q) + 1 >= IHL_LOCK_INSNS));

  // ==========================================================
  // Lock state machine
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q  <= LK_OPEN;
      cnt_q <= 3'h0;
    end else begin
      case (st_q)
        LK_OPEN: begin
          if (lk.trap || lk.exc_req) begin
            st_q  <= LK_HELD;
            cnt_q <= 3'h0;
          end
        end
        LK_HELD: begin
          if (last_w) begin
            st_q <= LK_OPEN;
          end
          if (lk.retire) begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default: st_q <= LK_OPEN;
      endcase
    end
  end

  // Accept or defer exception requests
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lk.take  <= 1'b0;
      lk.defer <= 1'b0;
    end else begin
      lk.take  <= lk.exc_req && open_w;
      lk.defer <= lk.exc_req && !open_w;
    end
  end

  assign lk.locked = (st_q == LK_HELD);
  assign lk.count  = cnt_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  lock_on_trap_a: assert property (open_w && lk.trap |=> lk.locked)
    else $error("trap did not lock");
  defer_locked_a: assert property (lk.exc_req && !open_w |=> lk.defer && !lk.take)
    else $error("exception not deferred");
  unlock_four_a: assert property (
    !open_w && lk.retire && !lk.taken && cnt_q == 3'h3 |=> !lk.locked)
    else $error("lock outlived four retires");
  hold_lock_a: assert property (
    !open_w && lk.retire && !lk.taken && cnt_q < 3'h3 |=> lk.locked)
    else $error("lock dropped early");
  cov_unlock_c: cover property (lk.locked ##1 !lk.locked);
  cov_defer_c: cover property (lk.defer ##[1:20] lk.take);
endmodule

/* verification/ihl_fw_model.sv */
// Purpose: Firmware instruction stream seen at the enqueue port
// Assumes: One instruction per call, driven on clk_in rising edges
// Notes:   PC and kind lines show a changing pattern once released; group line keeps its value
`timescale 1ns/1ps
module ihl_fw_model
  import ihl_pkg::*;
(
  input  wire logic  clk_in,
  output logic       enq_valid_out,
  output logic [15:0] enq_pc_out,
  output logic [2:0] enq_kind_out,
  output logic [2:0] enq_group_out
);
  // ==========================================
  // Idle state at time zero
  initial begin
    enq_valid_out = 1'b0;
    enq_pc_out    = 16'h0000;
    enq_kind_out  = 3'h0;
    enq_group_out = 3'h0;
  end
  // One enqueue; block in pc 15:4, slot in pc 3:2
  task automatic enq(input ihl_kind_e k, input logic [2:0] g, input logic [11:0] b,
                     input logic [1:0] s);
    @(posedge clk_in);
    enq_valid_out <= 1'b1;
    enq_pc_out    <= {b, s, 2'h0};
    enq_kind_out  <= k;
    enq_group_out <= g;
    @(posedge clk_in);
    enq_valid_out <= 1'b0;
    enq_pc_out    <= ~{b, s, 2'h0};
    enq_kind_out  <= ~k;
    #1;
  endtask
endmodule

/* verification/ihl_hazard_and_trap_lock_tb_top.sv */
// Purpose: Self-checking bench for the hazard and trap lock block
// Assumes: Slave answers with hreadyout; pulses are one cycle wide
// Notes:   Flag model is a plain integer updated beside the stimulus
`timescale 1ns/1ps
module ihl_hazard_and_trap_lock_tb_top
  import ihl_pkg::*;
;
  logic clk_in, arst_n_in, hsel_in, hwrite_in, priv_mode_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, r;
  logic [1:0] htrans_in, s;
  wire logic hready_in, hreadyout_out, hresp_out, enq_valid_in;
  wire logic [2:0] hsize_in, enq_kind_in, enq_group_in;
  wire logic [15:0] enq_pc_in;
  logic [15:0] replay_pc_in;
  logic [63:0] fetch_target_in, dvaddr_in;
  logic [11:0] pl, blk;
  logic [2:0] g;
  wire logic iss_move_from_in, iss_move_to_in, move_to_retire_in, replay_trap_in;
  wire logic refetch_issue_in, priv_jump_in, dvaddr_valid_in, trap_in, retire_in;
  wire logic taken_retire_in, exc_req_in, dfault_in;
  logic rmw_hold_out, hold_newer_ldst_out, cancel_dirty_out, ifetch_acv_out, dacv_out;
  logic fetch_wide_out, data_wide_out, exc_regs_wen_out, exc_defer_out;
  logic dfault_regs_wen_out;
  int n_fail, num_checks, seed, m;
  int blk_m;
  int grp_m[$];
  assign hready_in = hreadyout_out;
  assign hsize_in  = 3'h2;
  assign {dfault_in, exc_req_in, taken_retire_in, retire_in, trap_in, dvaddr_valid_in,
          priv_jump_in, refetch_issue_in, replay_trap_in, move_to_retire_in,
          iss_move_to_in, iss_move_from_in} = pl;
  // ==========================================
  // Design and firmware stream
  ihl_hazard_top dut_u (.clk_in, .arst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .enq_valid_in, .enq_pc_in, .enq_kind_in, .enq_group_in, .iss_move_from_in,
    .iss_move_to_in, .move_to_retire_in, .replay_trap_in, .replay_pc_in,
    .refetch_issue_in, .priv_mode_in, .priv_jump_in, .fetch_target_in, .dvaddr_valid_in,
    .dvaddr_in, .trap_in, .retire_in, .taken_retire_in, .exc_req_in, .dfault_in,
    .rmw_hold_out, .hold_newer_ldst_out, .cancel_dirty_out, .ifetch_acv_out, .dacv_out,
    .fetch_wide_out, .data_wide_out, .exc_regs_wen_out, .exc_defer_out,
    .dfault_regs_wen_out);
  ihl_fw_model fw_u (.clk_in, .enq_valid_out(enq_valid_in), .enq_pc_out(enq_pc_in),
    .enq_kind_out(enq_kind_in), .enq_group_out(enq_group_in));
  // ==========================================
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Wait for hready with a bound
  task automatic wrdy;
    int i;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (hreadyout_out !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h000000, a};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    wrdy();
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wrdy();
    r = hrdata_out;
  endtask
  // One-cycle pulse on the event lines, result seen after the next edge
  task automatic pulse(input logic [11:0] v);
    @(posedge clk_in);
    pl <= v;
    @(posedge clk_in);
    pl <= 12'h000;
    #1;
  endtask
  task automatic flags;
    ahb(1'b0, IHL_STATUS_OFF, 32'h0);
    chk("flags", r & 32'h3F, m);
    ahb(1'b1, IHL_STATUS_OFF, 32'h3F);
    m = 0;
  endtask
  // Rule model of the placement flags, kept beside each enqueue
  task automatic enq_m(input ihl_kind_e k, input logic [2:0] gr, input logic [11:0] b,
                       input logic [1:0] sl);
    bit hit;
    hit = 1'b0;
    if (int'(b) != blk_m) begin
      grp_m.delete();
    end
    blk_m = int'(b);
    foreach (grp_m[i]) begin
      if (grp_m[i] == int'(gr)) begin
        hit = 1'b1;
      end
    end
    if (hit && k == K_MOVE_TO) m = m | 1;
    if (hit && k == K_MOVE_FROM) m = m | 2;
    if (hit && k == K_IMPL_READ) m = m | 4;
    if (!hit && k == K_MOVE_TO) grp_m.push_back(int'(gr));
    fw_u.enq(k, gr, b, sl);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    seed            = 32'hB6CA668B;
    arst_n_in       = 1'b0;
    hsel_in         = 1'b0;
    haddr_in        = 32'h0;
    htrans_in       = 2'h0;
    hwrite_in       = 1'b0;
    hwdata_in       = 32'h0;
    pl              = 12'h000;
    m               = 0;
    blk_m           = 0;
    priv_mode_in    = 1'b1;
    replay_pc_in    = 16'h0;
    fetch_target_in = 64'h0;
    dvaddr_in       = 64'h0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    #1 chk("hreadyout", hreadyout_out, 1);
    chk("hresp", hresp_out, 0);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", r, 0);
    blk = 12'($random(seed));
    g = 3'($random(seed));
    enq_m(K_MOVE_TO, g, blk, 2'h0);
    enq_m(K_MOVE_TO, g + 3'h1, blk, 2'h1);
    flags();
    enq_m(K_MOVE_TO, g, blk, 2'h2);
    enq_m(K_MOVE_FROM, g, blk, 2'h3);
    enq_m(K_MOVE_TO, g, blk + 12'h1, 2'h0);
    enq_m(K_IMPL_READ, g, blk + 12'h1, 2'h1);
    flags();
    pulse(12'h001);
    chk("rmw_hold", rmw_hold_out, 1);
    repeat (2) @(posedge clk_in);
    #1 chk("rmw_hold", rmw_hold_out, 1);
    @(posedge clk_in);
    #1 chk("rmw_hold", rmw_hold_out, 0);
    pulse(12'h002);
    pulse(12'h001);
    pulse(12'h002);
    m = 8;
    flags();
    ahb(1'b0, IHL_GAP_OFF, 32'h0);
    chk("gap", r, 2);
    chk("rmw_hold", rmw_hold_out, 0);
    ahb(1'b1, IHL_IFETCH_CTRL_OFF, 32'h1);
    chk("fetch_wide", fetch_wide_out, 0);
    pulse(12'h004);
    @(posedge clk_in);
    #1 chk("fetch_wide", fetch_wide_out, 1);
    chk("data_wide", data_wide_out, 0);
    ahb(1'b0, IHL_IFETCH_CTRL_OFF, 32'h0);
    chk("committed", r[17:16], 1);
    fetch_target_in <= 64'h0000_0400_0000_0000;
    dvaddr_in       <= 64'h0000_0400_0000_0000;
    pulse(12'h060);
    chk("ifetch_acv", ifetch_acv_out, 0);
    chk("dacv", dacv_out, 1);
    fetch_target_in <= 64'h0001_0000_0000_0000;
    pulse(12'h020);
    chk("ifetch_acv", ifetch_acv_out, 1);
    priv_mode_in <= 1'b0;
    m = 48;
    flags();
    priv_mode_in <= 1'b1;
    ahb(1'b1, IHL_STATUS_OFF, 32'h3F);
    ahb(1'b1, IHL_VADDR_CTRL_OFF, 32'h1);
    pulse(12'h004);
    @(posedge clk_in);
    #1 chk("data_wide", data_wide_out, 1);
    s = 2'($random(seed));
    replay_pc_in <= {blk, s, 2'h0};
    pulse(12'h008);
    chk("hold_newer", hold_newer_ldst_out, 1);
    enq_m(K_FP_STORE, 3'h0, blk, s ^ 2'h1);
    chk("cancel", cancel_dirty_out, 0);
    enq_m(K_FP_STORE, 3'h0, blk, s);
    chk("cancel", cancel_dirty_out, 1);
    enq_m(K_FP_STORE, 3'h0, blk, s);
    chk("cancel", cancel_dirty_out, 0);
    pulse(12'h010);
    chk("hold_newer", hold_newer_ldst_out, 0);
    pulse(12'h400);
    chk("exc_wen", exc_regs_wen_out, 1);
    pulse(12'hC00);
    chk("defer", exc_defer_out, 1);
    chk("exc_wen", exc_regs_wen_out, 0);
    chk("dfault_wen", dfault_regs_wen_out, 1);
    repeat (3) pulse(12'h100);
    ahb(1'b0, IHL_STATUS_OFF, 32'h0);
    chk("lock_state", r[14:8], 7'h31);
    pulse(12'h400);
    chk("defer", exc_defer_out, 1);
    pulse(12'h100);
    pulse(12'h400);
    chk("exc_wen", exc_regs_wen_out, 1);
    pulse(12'h300);
    pulse(12'h400);
    chk("exc_wen", exc_regs_wen_out, 1);
    pulse(12'h100);
    pulse(12'h300);
    pulse(12'h080);
    pulse(12'h400);
    chk("defer", exc_defer_out, 1);
    report_and_stop();
  end
endmodule
